// *** dv/pdsc_top_test.sv ***
`timescale 1ns/1ps
module pdsc_top_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [6:0] bank_src_edge = 7'h0;
   logic pfd_tick = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, spread_active;
   logic pll3_spread_enable, pll3_ref_unusable;
   logic [6:0] bank_clk, bank_oe_n;
   pdsc_pkg::pdsc_pll_div_t [3:0] pll_div;
   logic [13:0] pll0_mult;
   logic [11:0] pll1_mult, pll2_mult, pll3_mult;
   logic [2:0] pll_power_down;
   logic signed [9:0] spread_mod;
   logic [7:0] pll3_spread_ref_divide;
   logic [15:0] pll3_spread_loop_count;
   logic rd_pend = 1'b0;
   logic [31:0] exp_q[$];
   int err_total = 0;
   int n_checks = 0;
   integer seed = 92561;
   wire [35:0] m123 = {pll3_mult, pll2_mult, pll1_mult};

   pdsc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .bank_src_edge(bank_src_edge), .pfd_tick(pfd_tick),
      .bank_clk(bank_clk), .bank_oe_n(bank_oe_n), .pll_div(pll_div),
      .pll0_mult(pll0_mult), .pll1_mult(pll1_mult), .pll2_mult(pll2_mult),
      .pll3_mult(pll3_mult), .pll_power_down(pll_power_down),
      .pll3_ref_unusable(pll3_ref_unusable), .spread_active(spread_active),
      .spread_mod(spread_mod), .pll3_spread_enable(pll3_spread_enable),
      .pll3_spread_ref_divide(pll3_spread_ref_divide),
      .pll3_spread_loop_count(pll3_spread_loop_count));

   initial begin
      forever #20 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one single ahb-lite transfer; a read notes its expected word
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      rd_pend <= !w;
      if (!w) exp_q.push_back(d);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask

   always @(posedge hclk) begin
      if (rd_pend && hreadyout === 1'b1 && exp_q.size() > 0) begin
         chk(hrdata, exp_q.pop_front());
      end
   end

   task automatic pulse(input int b);
      bank_src_edge <= 7'(1 << b);
      @(posedge hclk);
      bank_src_edge <= 7'h0;
      @(posedge hclk);
   endtask

   // source pulses between two toggles of a bank clock
   task automatic bank_ratio(input int b, input int r);
      int n;
      logic v;
      for (int k = 0; k < 2; k++) begin
         v = bank_clk[b];
         n = 0;
         while (bank_clk[b] === v && n < 600) begin
            pulse(b);
            n++;
         end
      end
      chk(32'(n), 32'(r));
   endtask

   // detector ticks until the masked modulator value moves
   task automatic tick_step(input logic [9:0] msk, output int n);
      logic [9:0] v;
      v = spread_mod & msk;
      n = 0;
      while ((spread_mod & msk) === v && n < 40) begin
         pfd_tick <= 1'b1;
         @(posedge hclk);
         pfd_tick <= 1'b0;
         repeat (2) @(posedge hclk);
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 60000);
      err_total++;
      test_done();
   end

   initial begin
      logic [11:0] n;
      logic [3:0] a;
      logic [6:0] c;
      logic [31:0] r;
      logic [9:0] msk;
      int p;
      int t;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(8'h00, 1'b0, 32'h00000c01);
      xfer(8'h0c, 1'b0, 32'h00000c03);
      xfer(8'h10, 1'b0, 32'h000c0018);
      xfer(8'h20, 1'b0, 32'h0000017f);
      xfer(8'hfc, 1'b0, 32'h0);
      xfer(8'h00, 1'b1, 32'hffffffff);
      xfer(8'h00, 1'b0, 32'h0f0fff7f);
      xfer(8'h04, 1'b1, 32'h00000c00);
      xfer(8'h0c, 1'b1, 32'h00000c02);
      xfer(8'h38, 1'b0, 32'h0000000a);
      xfer(8'h0c, 1'b1, 32'h00000c03);
      for (int i = 0; i < 8; i++) begin
         n = 12'($random(seed));
         a = (i % 2 == 1) ? 4'($random(seed)) : 4'h0;
         xfer(8'h00, 1'b1, {4'h0, a, 4'h0, n, 8'h01});
         @(posedge hclk);
         chk(32'(pll0_mult),
             32'(n) * 2 + 32'(a) + 32'(a != 4'h0));
         p = 1 + i % 3;
         xfer(8'(4 * p), 1'b1, {12'h0, n, 8'h05});
         @(posedge hclk);
         chk(32'(m123[12*(p-1) +: 12]), 32'(n));
      end
      for (int m = 0; m < 4; m++) begin
         xfer(8'(32 + 4 * m), 1'b1, {21'h0, 2'(m), 2'h0, 7'h7f});
         repeat (2) @(posedge hclk);
         pulse(m + 1);
         pulse(m + 1);
         chk(32'(bank_oe_n[m+1]), 32'(m >= 2));
         if (m < 2) chk(32'(bank_clk[m+1]), 32'(m));
      end
      for (int b = 1; b < 7; b++) begin
         c = 7'($random(seed));
         if (c == 7'h7f) c = 7'h00;
         if (b == 1) c = 7'h7f;
         xfer(8'(28 + 4 * b), 1'b1, {23'h0, b != 2, 1'b0, c});
         repeat (2) @(posedge hclk);
         chk(32'(bank_oe_n[b]), 32'h0);
         bank_ratio(b, b == 1 ? 1 : b == 2 ? 2 :
                    (int'(c) + 2) * 2);
      end
      bank_ratio(0, 1);
      xfer(8'h00, 1'b1, 32'h01006001);
      xfer(8'hb0, 1'b1, 32'h00000053);
      for (int m = 0; m < 3; m++) begin
         msk = (m == 2) ? 10'h3fe : 10'h3ff;
         xfer(8'hac, 1'b1,
              {14'h0, m == 1, m == 2, 2'h0, 6'h04, 8'h15});
         repeat (2) @(posedge hclk);
         chk(32'(spread_active), 32'h1);
         for (int s = 0; s < 3; s++) begin
            tick_step(msk, t);
            chk(32'(t), 32'h7);
            r = 32'h4 + ((s == 1 ? 32'h8 : 32'h3) << (m == 1));
            chk(32'(spread_mod & msk),
                r & 32'(msk));
         end
         xfer(8'hac, 1'b1, 32'h0);
         repeat (2) @(posedge hclk);
         chk(32'(spread_active), 32'h0);
         chk(32'(spread_mod), 32'h0);
      end
      r = $random(seed);
      xfer(8'h4c, 1'b1, {16'h0, r[7:0], 8'h01});
      xfer(8'h50, 1'b1, {16'h0, r[23:8]});
      xfer(8'h50, 1'b0, {16'h0, r[23:8]});
      chk(32'(pll3_spread_enable), 32'h1);
      chk(32'(pll3_spread_ref_divide), 32'(r[7:0]));
      chk(32'(pll3_spread_loop_count), 32'(r[23:8]));
      test_done();
   end
endmodule

// *** rtl/pdsc_out_div.sv ***
`timescale 1ns/1ps
module pdsc_out_div #(
   parameter int CODE_W = 7
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire pdsc_pkg::pdsc_out_cfg_t cfg,
   input wire logic src_edge,
   output logic clk_out,
   output logic out_oe_n,
   output logic disabled
);
   initial begin
      if (CODE_W != 7) $error("pdsc_out_div: CODE_W must be 7");
   end

   logic [8:0] cnt_r;
   logic [8:0] cnt_nxt;
   logic clk_r;
   logic clk_nxt;
   logic oe_n_r;
   logic oe_n_nxt;
   wire all_ones = &cfg.code;
   wire mode = cfg.divider_mode_bit;
   wire [8:0] q_div = ({2'h0, cfg.code} + 9'h002) << 1;
   // ratio in source edges per output edge
   wire [8:0] ratio = (all_ones && mode) ? 9'h001 :
                      (!mode) ? 9'h002 : q_div;
   assign disabled = all_ones && !mode;
   wire wrap = (cnt_r >= ratio - 9'h001);
   wire [1:0] drv_mode = cfg.disabled_output_drive_mode;
   localparam logic [1:0] DRV_HIGH_L = pdsc_pkg::DRV_HIGH;

   always_comb begin
      cnt_nxt = cnt_r;
      clk_nxt = clk_r;
      oe_n_nxt = 1'b0;
      if (disabled) begin
         // stays powered, no clock, parked per drive mode
         cnt_nxt = 9'h000;
         clk_nxt = (drv_mode == DRV_HIGH_L);
         oe_n_nxt = drv_mode[1];
      end else if (src_edge) begin
         cnt_nxt = wrap ? 9'h000 : cnt_r + 9'h001;
         clk_nxt = wrap ? !clk_r : clk_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 9'h000;
         clk_r <= 1'b0;
         oe_n_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         clk_r <= clk_nxt;
         oe_n_r <= oe_n_nxt;
      end
   end
   assign clk_out = clk_r;
   assign out_oe_n = oe_n_r;

   chk_disabled_park: assert property (
      @(posedge hclk) disable iff (!hresetn)
      disabled && $stable(cfg) ##1 disabled |->
         out_oe_n == drv_mode[1] && (drv_mode[1]
            || clk_out == (drv_mode == DRV_HIGH_L)))
      else $error("disabled output not parked per drive mode");
   chk_div_one: assert property (
      @(posedge hclk) disable iff (!hresetn)
      all_ones && mode && $stable(cfg) && src_edge
         && $past(all_ones && mode) |=> clk_out != $past(clk_out))
      else $error("divide by one did not toggle on source edge");
endmodule

// *** rtl/pdsc_pkg.sv ***
package pdsc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_PLL0_DIV = 8'h00;
   localparam logic [7:0] OFS_PLL1_DIV = 8'h04;
   localparam logic [7:0] OFS_PLL2_DIV = 8'h08;
   localparam logic [7:0] OFS_PLL3_DIV = 8'h0c;
   localparam logic [7:0] OFS_MULT01 = 8'h10;
   localparam logic [7:0] OFS_MULT23 = 8'h14;
   localparam logic [7:0] OFS_BANK1 = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h38;
   localparam logic [7:0] OFS_P3_CTRL = 8'h4c;
   localparam logic [7:0] OFS_P3_LOOP = 8'h50;
   localparam logic [7:0] OFS_SS_CTRL = 8'hac;
   localparam logic [7:0] OFS_SS_SDLO = 8'hb0;
   localparam logic [7:0] OFS_SS_SDHI = 8'hb4;
   localparam logic [7:0] OFS_SS_STAT = 8'hb8;
   // field positions
   localparam int POS_REF = 0;
   localparam int POS_FB = 8;
   localparam int POS_ADD = 24;
   localparam int POS_MODE = 8;
   localparam int POS_DRV = 9;
   localparam int POS_NSSC = 4;
   localparam int POS_OFS = 8;
   localparam int POS_DITHER = 16;
   localparam int POS_DBL = 17;
   localparam int POS_P3EN = 0;
   localparam int POS_P3REF = 8;
   // values after reset
   localparam logic [6:0] RST_REF = 7'h01;
   localparam logic [6:0] RST_REF3 = 7'h03;
   localparam logic [11:0] RST_FB = 12'h00c;
   localparam logic [6:0] RST_CODE = 7'h7f;
   localparam logic RST_MODE = 1'b1;
   localparam logic [7:0] RST_LFSR = 8'h01;
   // counts
   localparam int NUM_BANKS = 6;
   localparam int NUM_SD = 12;
   localparam logic [4:0] TSSC_ADD = 5'h02;
   localparam logic [6:0] REF_MIN3 = 7'h03;
   // disabled output drive
   localparam logic [1:0] DRV_LOW = 2'h0;
   localparam logic [1:0] DRV_HIGH = 2'h1;

   typedef struct packed {
      logic [3:0] add;
      logic [11:0] fb_div;
      logic [6:0] ref_div;
   } pdsc_pll_div_t;

   typedef struct packed {
      logic [1:0] disabled_output_drive_mode;
      logic divider_mode_bit;
      logic [6:0] code;
   } pdsc_out_cfg_t;

   typedef struct packed {
      logic sel;
      logic [1:0] trans;
      logic write;
      logic [2:0] size;
      logic [31:0] addr;
   } pdsc_ahb_req_t;
endpackage

// *** rtl/pdsc_top.sv ***
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module pdsc_top #(
   parameter int NBANK = 6,
   parameter int NSD = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NBANK:0] bank_src_edge,
   input wire logic pfd_tick,
   output logic [NBANK:0] bank_clk,
   output logic [NBANK:0] bank_oe_n,
   output pdsc_pkg::pdsc_pll_div_t [3:0] pll_div,
   output logic [13:0] pll0_mult,
   output logic [11:0] pll1_mult,
   output logic [11:0] pll2_mult,
   output logic [11:0] pll3_mult,
   output logic [2:0] pll_power_down,
   output logic pll3_ref_unusable,
   output logic spread_active,
   output logic signed [9:0] spread_mod,
   output logic pll3_spread_enable,
   output logic [7:0] pll3_spread_ref_divide,
   output logic [15:0] pll3_spread_loop_count
);
   initial begin
      if (NBANK != pdsc_pkg::NUM_BANKS || NSD != pdsc_pkg::NUM_SD)
         $error("pdsc_top: bank and sample counts are fixed");
   end

   ////////////////////////////////////////////////////////////////////////
   // bus slave
   pdsc_pkg::pdsc_ahb_req_t req;
   assign req = '{sel: hsel, trans: htrans, write: hwrite, size: hsize,
                  addr: haddr};
   wire take = req.sel && req.trans[1] && hready;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] rdata_r;
   wire [7:0] ra = req.addr[7:0];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= take && req.write;
         wr_addr_r <= req.addr[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   pdsc_pkg::pdsc_pll_div_t [3:0] div_r;
   pdsc_pkg::pdsc_out_cfg_t [NBANK-1:0] bank_r;
   logic [3:0] tssc_r;
   logic [2:0] nssc_r;
   logic [5:0] ofs_r;
   logic dither_r;
   logic dbl_r;
   logic [NSD-1:0][3:0] delta_r;
   logic [NBANK-1:0] bank_dis;
   logic p3en_r;
   logic [7:0] p3ref_r;
   logic [15:0] p3loop_r;
   wire wr_ss = wr_pend_r && wr_addr_r == pdsc_pkg::OFS_SS_CTRL;
   wire wr_sdlo = wr_pend_r && wr_addr_r == pdsc_pkg::OFS_SS_SDLO;
   wire wr_sdhi = wr_pend_r && wr_addr_r == pdsc_pkg::OFS_SS_SDHI;
   wire wr_p3c = wr_pend_r && wr_addr_r == pdsc_pkg::OFS_P3_CTRL;
   wire wr_p3l = wr_pend_r && wr_addr_r == pdsc_pkg::OFS_P3_LOOP;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_pll
         wire hit = wr_pend_r && wr_addr_r == 8'(g * 4);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               div_r[g].ref_div <= (g == 3) ? pdsc_pkg::RST_REF3
                                            : pdsc_pkg::RST_REF;
               div_r[g].fb_div <= pdsc_pkg::RST_FB;
               div_r[g].add <= 4'h0;
            end else if (hit) begin
               div_r[g].ref_div <= hwdata[pdsc_pkg::POS_REF +: 7];
               div_r[g].fb_div <= hwdata[pdsc_pkg::POS_FB +: 12];
               div_r[g].add <= (g == 0) ? hwdata[pdsc_pkg::POS_ADD +: 4]
                                        : 4'h0;
            end
         end
      end
      for (g = 0; g < NBANK; g++) begin : g_bank
         wire hit = wr_pend_r && wr_addr_r == pdsc_pkg::OFS_BANK1 + 8'(g * 4);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               bank_r[g].code <= pdsc_pkg::RST_CODE;
               bank_r[g].divider_mode_bit <= pdsc_pkg::RST_MODE;
               bank_r[g].disabled_output_drive_mode <= pdsc_pkg::DRV_LOW;
            end else if (hit) begin
               bank_r[g].code <= hwdata[6:0];
               bank_r[g].divider_mode_bit <= hwdata[pdsc_pkg::POS_MODE];
               bank_r[g].disabled_output_drive_mode <=
                  hwdata[pdsc_pkg::POS_DRV +: 2];
            end
         end
         // banks 1..6 own a divider
         pdsc_out_div #(.CODE_W(7)) u_div (
            .hclk(hclk),
            .hresetn(hresetn),
            .cfg(bank_r[g]),
            .src_edge(bank_src_edge[g+1]),
            .clk_out(bank_clk[g+1]),
            .out_oe_n(bank_oe_n[g+1]),
            .disabled(bank_dis[g])
         );
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tssc_r <= 4'h0;
         nssc_r <= 3'h0;
         ofs_r <= 6'h00;
         dither_r <= 1'b0;
         dbl_r <= 1'b0;
         delta_r <= '0;
         p3en_r <= 1'b0;
         p3ref_r <= 8'h00;
         p3loop_r <= 16'h0000;
      end else begin
         if (wr_ss) begin
            tssc_r <= hwdata[3:0];
            nssc_r <= hwdata[pdsc_pkg::POS_NSSC +: 3];
            ofs_r <= hwdata[pdsc_pkg::POS_OFS +: 6];
            dither_r <= hwdata[pdsc_pkg::POS_DITHER];
            dbl_r <= hwdata[pdsc_pkg::POS_DBL];
         end
         if (wr_sdlo) delta_r[7:0] <= hwdata;
         if (wr_sdhi) delta_r[11:8] <= hwdata[15:0];
         if (wr_p3c) begin
            p3en_r <= hwdata[pdsc_pkg::POS_P3EN];
            p3ref_r <= hwdata[pdsc_pkg::POS_P3REF +: 8];
         end
         if (wr_p3l) p3loop_r <= hwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // multipliers and power state
   wire [13:0] n2 = {1'b0, div_r[0].fb_div, 1'b0};
   assign pll0_mult = (div_r[0].add != 4'h0) ?
                      n2 + {10'h000, div_r[0].add} + 14'h0001 : n2;
   assign pll1_mult = div_r[1].fb_div;
   assign pll2_mult = div_r[2].fb_div;
   assign pll3_mult = div_r[3].fb_div;
   assign pll_div = div_r;
   generate
      for (g = 0; g < 3; g++) begin : g_pd
         assign pll_power_down[g] = div_r[g].ref_div == 7'h00;
      end
   endgenerate
   assign pll3_ref_unusable =
      div_r[3].ref_div < pdsc_pkg::REF_MIN3;
   assign pll3_spread_enable = p3en_r;
   assign pll3_spread_ref_divide = p3ref_r;
   assign pll3_spread_loop_count = p3loop_r;

   // bank 0 follows its source with no divider
   logic b0_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) b0_r <= 1'b0;
      else if (bank_src_edge[0]) b0_r <= !b0_r;
   end
   assign bank_clk[0] = b0_r;
   assign bank_oe_n[0] = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // spread modulator
   logic [4:0] step_cnt_r;
   logic [3:0] idx_r;
   logic [1:0] quad_r;
   logic [7:0] acc_r;
   logic [7:0] lfsr_r;
   logic signed [9:0] mod_r;
   assign spread_active = tssc_r != 4'h0;
   wire [4:0] t_len = {1'b0, tssc_r} + pdsc_pkg::TSSC_ADD;
   wire [4:0] n_len = {1'b0, nssc_r, 1'b0};
   wire step_p = spread_active && pfd_tick
                 && step_cnt_r == t_len - 5'h01;
   wire [3:0] delta_cur = (idx_r < 4'(NSD)) ? delta_r[idx_r] : 4'h0;
   wire fwd_end = {1'b0, idx_r} + 5'h01 >= n_len;
   wire rising = !quad_r[0];
   // forward in even quadrants, backward in odd ones
   wire [7:0] acc_nxt = rising ? acc_r + {4'h0, delta_cur}
                               : acc_r - {4'h0, delta_cur};
   wire turn = rising ? fwd_end : idx_r == 4'h0;
   wire [8:0] mag = dbl_r ? {acc_r, 1'b0} : {1'b0, acc_r};
   wire signed [9:0] smag = quad_r[1] ? -$signed({1'b0, mag})
                                      : $signed({1'b0, mag});
   wire signed [9:0] mod_sum = smag + $signed({4'h0, ofs_r});
   wire lfsr_fb = lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3];
   wire dither_bit = dither_r & lfsr_r[0];
   wire signed [9:0] mod_nxt = {mod_sum[9:1], mod_sum[0] ^ dither_bit};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lfsr_r <= pdsc_pkg::RST_LFSR;
      end else if (pfd_tick) begin
         lfsr_r <= {lfsr_r[6:0], lfsr_fb};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         step_cnt_r <= 5'h00;
         idx_r <= 4'h0;
         quad_r <= 2'h0;
         acc_r <= 8'h00;
      end else if (!spread_active) begin
         step_cnt_r <= 5'h00;
         idx_r <= 4'h0;
         quad_r <= 2'h0;
         acc_r <= 8'h00;
      end else if (pfd_tick) begin
         step_cnt_r <= step_p ? 5'h00 : step_cnt_r + 5'h01;
         if (step_p) begin
            acc_r <= acc_nxt;
            quad_r <= turn ? quad_r + 2'h1 : quad_r;
            if (!turn) idx_r <= rising ? idx_r + 4'h1 : idx_r - 4'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) mod_r <= 10'sh000;
      else mod_r <= spread_active ? mod_nxt : 10'sh000;
   end
   assign spread_mod = mod_r;

   ////////////////////////////////////////////////////////////////////////
   // read data
   logic [31:0] rd_mux;
   wire [2:0] bank_rd = 3'((ra - pdsc_pkg::OFS_BANK1) >> 2);
   pdsc_pkg::pdsc_out_cfg_t bank_sel;
   assign bank_sel = bank_r[bank_rd];
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (ra)
         pdsc_pkg::OFS_PLL0_DIV,
         pdsc_pkg::OFS_PLL1_DIV,
         pdsc_pkg::OFS_PLL2_DIV,
         pdsc_pkg::OFS_PLL3_DIV: begin
            rd_mux = {4'h0, div_r[ra[3:2]].add, 4'h0,
                      div_r[ra[3:2]].fb_div, 1'b0, div_r[ra[3:2]].ref_div};
         end
         pdsc_pkg::OFS_MULT01: rd_mux = {4'h0, pll1_mult, 2'h0, pll0_mult};
         pdsc_pkg::OFS_MULT23: rd_mux = {4'h0, pll3_mult, 4'h0, pll2_mult};
         pdsc_pkg::OFS_STATUS: begin
            rd_mux = {20'h00000, 2'h0, bank_dis, pll3_ref_unusable,
                      pll_power_down};
         end
         pdsc_pkg::OFS_P3_CTRL: rd_mux = {16'h0000, p3ref_r, 7'h00, p3en_r};
         pdsc_pkg::OFS_P3_LOOP: rd_mux = {16'h0000, p3loop_r};
         pdsc_pkg::OFS_SS_CTRL: begin
            rd_mux = {14'h0, dbl_r, dither_r, 2'h0, ofs_r, 1'b0, nssc_r,
                      tssc_r};
         end
         pdsc_pkg::OFS_SS_SDLO: rd_mux = delta_r[7:0];
         pdsc_pkg::OFS_SS_SDHI: rd_mux = {16'h0000, delta_r[11:8]};
         pdsc_pkg::OFS_SS_STAT: begin
            rd_mux = {6'h00, mod_r, acc_r, 2'h0, quad_r, idx_r};
         end
         default: begin
            if (ra >= pdsc_pkg::OFS_BANK1 && ra < pdsc_pkg::OFS_STATUS)
               rd_mux = {21'h0, bank_sel.disabled_output_drive_mode,
                         bank_sel.divider_mode_bit, 1'b0, bank_sel.code};
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rdata_r <= 32'h0000_0000;
      else if (take && !req.write) rdata_r <= rd_mux;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_step;
      step_p;
   endsequence
   sequence s_gap;
      !step_p [*3];
   endsequence

   chk_pll0_mult: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pll0_mult == ((div_r[0].add == 4'h0) ? 14'(2 * div_r[0].fb_div)
         : 14'(2 * div_r[0].fb_div + div_r[0].add + 1)))
      else $error("pll0 multiplier formula broken");
   chk_other_mult: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pll2_mult == pll_div[2].fb_div && pll3_mult == pll_div[3].fb_div)
      else $error("plain multiplier differs from feedback value");
   chk_power_down: assert property (
      @(posedge hclk) disable iff (!hresetn)
      pll_power_down[0] == (pll_div[0].ref_div == 7'h00)
         && pll3_ref_unusable == (pll_div[3].ref_div <= 7'h02))
      else $error("power down decode wrong");
   chk_step_gap: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_step and (tssc_r >= 4'h5)) |=> s_gap)
      else $error("modulation steps closer than the minimum period");
   chk_spread_off: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !spread_active |=> spread_mod == 10'sh000 && acc_r == 8'h00)
      else $error("modulation present with step period zero");
   chk_step_accum: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_step and rising) |=> acc_r == $past(acc_r) + 8'($past(delta_cur)))
      else $error("rising step did not add its delta");
   chk_mirror_turn: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (s_step and turn) |=> quad_r == $past(quad_r) + 2'h1
         && idx_r == $past(idx_r))
      else $error("quadrant turn moved the sample index");
   chk_mod_sign: assert property (
      @(posedge hclk) disable iff (!hresetn)
      spread_active && !dither_r && !dbl_r && $stable(quad_r) ##1
         spread_active && !dither_r |->
         spread_mod == $past(smag) + $signed({4'h0, $past(ofs_r)}))
      else $error("modulator output not offset plus signed sample");
   chk_double_amp: assert property (
      @(posedge hclk) disable iff (!hresetn)
      spread_active && dbl_r && !quad_r[1] && !dither_r |=>
         spread_mod == $signed({1'b0, $past(acc_r), 1'b0})
            + $signed({4'h0, $past(ofs_r)}))
      else $error("doubled amplitude not applied");
   chk_bus_okay: assert property (
      @(posedge hclk) disable iff (!hresetn)
      take && !req.write |=> hreadyout && !hresp)
      else $error("slave did not answer okay with zero wait");
endmodule
